// ---- hw/adc_conversion_mode_sequencer.v ----
`include "adc_seq_regs.vh"

// How it works
// - temperature select converts the internal sensor
// - temperature mode ignores cfg0, forces internal reference
// - 14-bit temperature left-justified in 24-bit word
// - result read most significant byte first
// - temperature code 0.03125 C, twos complement
// - temperature code passed unchanged from sensor
// - 50 us internal reset after power-up
// - reset loads defaults, single-shot mode
// - one default conversion after reset, then idle
// - one bit picks single-shot or continuous
// - single-shot converts once per start, then idles
// - single-shot config write restarts one conversion
// - continuous stores result, starts next immediately
// - first conversion 210 or 114 clocks after start
// - continuous config write restarts current conversion
// - normal mode modulator is clock over 16
// - three-bit rate field selects conversion period
// - duty mode: one conversion, three idle periods
// - turbo mode modulator is clock over 8
// - sleep finishes conversion; start wakes device
// - ready low on new data, high on read
module adc_conversion_mode_sequencer #(
   parameter RESET_CYCLES = `PWRUP_CYCLES,
   parameter PERIOD_SHIFT = 0
) (
   // clock and reset
   input wire CLOCK,
   input wire RST,
   // wishbone slave
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   // front-end results
   input wire [23:0] SAMPLE_IN,
   input wire [13:0] TEMP_IN,
   // front-end control
   output reg ANALOG_ON,
   output reg OSC_ON,
   output reg EXCITATION_ON,
   output reg INTERNAL_REF,
   output reg TEMP_SENSE,
   output reg [7:0] INPUT_CFG,
   output reg CONVERTING,
   // data ready
   output reg DATA_READY_N
);

   localparam S_RESET = 3'd0;
   localparam S_IDLE = 3'd1;
   localparam S_DELAY = 3'd2;
   localparam S_CONV = 3'd3;
   localparam S_DUTY = 3'd4;
   localparam S_SLEEP = 3'd5;

   localparam [31:0] RESET_SPAN = RESET_CYCLES;
   localparam [15:0] RESET_LAST = RESET_SPAN[15:0] - 16'h0001;

   reg [7:0] cfg0;
   reg [7:0] cfg1;
   reg [7:0] cfg2;
   reg [7:0] cfg3;
   reg [23:0] result;
   reg [2:0] state;
   reg [15:0] wait_cnt;
   reg [15:0] conv_cnt;
   reg [1:0] duty_left;
   reg run_cont;
   reg sleep_pending;
   reg [31:0] rd_word;

   function [15:0] conv_ticks;
      input [2:0] rate;
      begin
         case (rate)
            3'd0: conv_ticks = `PER_DR0;
            3'd1: conv_ticks = `PER_DR1;
            3'd2: conv_ticks = `PER_DR2;
            3'd3: conv_ticks = `PER_DR3;
            3'd4: conv_ticks = `PER_DR4;
            3'd5: conv_ticks = `PER_DR5;
            default: conv_ticks = `PER_DR6;
         endcase
      end
   endfunction

   // configuration fields
   wire [2:0] data_rate_field = cfg1[`DR_MSB:`DR_LSB];
   wire [1:0] op_mode = cfg1[`OPM_MSB:`OPM_LSB];
   wire conversion_mode_bit = cfg1[`CM_BIT];
   wire temp_sensor_select = cfg1[`TS_BIT];
   wire turbo = (op_mode == `OPM_TURBO);
   wire duty = (op_mode == `OPM_DUTY);
   wire [15:0] period = conv_ticks(data_rate_field) >> PERIOD_SHIFT;
   wire [15:0] period_last = period - 16'h0001;
   wire [15:0] ready_rise = period - 16'h0003;
   wire [15:0] start_last = {8'h00, turbo ? `START_DLY_TURBO : `START_DLY_NORMAL} - 16'h0001;

   // bus decode
   wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wr = req & WB_WE_I & WB_SEL_I[0];
   wire rd = req & ~WB_WE_I;
   wire in_reset = (state == S_RESET);
   wire adr_cfg = (WB_ADR_I == `OFS_CFG0) | (WB_ADR_I == `OFS_CFG1) |
                  (WB_ADR_I == `OFS_CFG2) | (WB_ADR_I == `OFS_CFG3);
   // host must stay quiet during the power-up reset; writes then are dropped, except a reset command
   wire cfg_wr = wr & adr_cfg & ~in_reset;
   wire cmd_wr = wr & (WB_ADR_I == `OFS_CMD);
   wire cmd_start = cmd_wr & ~in_reset & (WB_DAT_I[7:1] == `CMD_START);
   wire sleep_command = cmd_wr & ~in_reset & (WB_DAT_I[7:1] == `CMD_SLEEP);
   wire cmd_reset = cmd_wr & (WB_DAT_I[7:1] == `CMD_RESET);
   wire data_read = rd & (WB_ADR_I == `OFS_DATA);

   wire busy_conv = (state == S_CONV) | (state == S_DELAY);
   wire running = busy_conv | (state == S_DUTY);
   wire mod_tick;
   wire conv_done = (state == S_CONV) & mod_tick & (conv_cnt == period_last);
   wire go_sleep = sleep_pending | sleep_command;

   mod_tick_gen u_tick (
      .clk(CLOCK),
      .rst(RST),
      .run((state == S_CONV) | (state == S_DUTY)),
      .turbo(turbo),
      .tick(mod_tick)
   );

   // bus slave, one wait state
   always @(posedge CLOCK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= req;
      end
   end

   always @* begin
      rd_word = 32'h0000_0000;
      case (WB_ADR_I)
         `OFS_CFG0: rd_word = {24'h00_0000, cfg0};
         `OFS_CFG1: rd_word = {24'h00_0000, cfg1};
         `OFS_CFG2: rd_word = {24'h00_0000, cfg2};
         `OFS_CFG3: rd_word = {24'h00_0000, cfg3};
         `OFS_DATA: rd_word = {8'h00, result};
         `OFS_STATUS: rd_word = {24'h00_0000, 2'b00, run_cont, sleep_pending, DATA_READY_N, state};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (rd) begin
         WB_DAT_O <= rd_word;
      end else begin
         WB_DAT_O <= 32'h0000_0000;
      end
   end

   // configuration registers
   always @(posedge CLOCK) begin
      if (RST || cmd_reset) begin
         cfg0 <= `CFG0_RST;
         cfg1 <= `CFG1_RST;
         cfg2 <= `CFG2_RST;
         cfg3 <= `CFG3_RST;
      end else if (cfg_wr) begin
         case (WB_ADR_I)
            `OFS_CFG0: cfg0 <= WB_DAT_I[7:0];
            `OFS_CFG1: cfg1 <= WB_DAT_I[7:0];
            `OFS_CFG2: cfg2 <= WB_DAT_I[7:0];
            default: cfg3 <= WB_DAT_I[7:0];
         endcase
      end
   end

   // sequencer
   always @(posedge CLOCK) begin
      if (RST || cmd_reset) begin
         state <= S_RESET;
         wait_cnt <= 16'h0000;
         conv_cnt <= 16'h0000;
         duty_left <= 2'h0;
         run_cont <= 1'b0;
         sleep_pending <= 1'b0;
      end else if (cmd_start) begin
         // also the wake-up path out of sleep
         state <= S_DELAY;
         wait_cnt <= 16'h0000;
         conv_cnt <= 16'h0000;
         run_cont <= conversion_mode_bit;
         sleep_pending <= 1'b0;
      end else if (cfg_wr && run_cont && running) begin
         // restart in place, keep continuous running
         if (state == S_CONV) begin
            conv_cnt <= 16'h0000;
         end
      end else if (cfg_wr) begin
         // acts as a start but only ever for one conversion
         state <= S_DELAY;
         wait_cnt <= 16'h0000;
         conv_cnt <= 16'h0000;
         run_cont <= 1'b0;
         sleep_pending <= 1'b0;
      end else begin
         if (sleep_command && busy_conv) begin
            sleep_pending <= 1'b1;
         end
         case (state)
            S_RESET: begin
               if (wait_cnt >= RESET_LAST) begin
                  state <= S_DELAY;
                  wait_cnt <= 16'h0000;
                  run_cont <= 1'b0;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            S_DELAY: begin
               if (wait_cnt >= start_last) begin
                  state <= S_CONV;
                  wait_cnt <= 16'h0000;
                  conv_cnt <= 16'h0000;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            S_CONV: begin
               if (conv_done) begin
                  conv_cnt <= 16'h0000;
                  if (go_sleep) begin
                     state <= S_SLEEP;
                     sleep_pending <= 1'b0;
                     run_cont <= 1'b0;
                  end else if (run_cont && duty) begin
                     state <= S_DUTY;
                     duty_left <= `DUTY_IDLE_PERIODS - 2'h1;
                  end else if (run_cont) begin
                     state <= S_CONV;
                  end else begin
                     state <= S_IDLE;
                  end
               end else if (mod_tick) begin
                  conv_cnt <= conv_cnt + 16'h0001;
               end
            end
            S_DUTY: begin
               if (sleep_command) begin
                  state <= S_SLEEP;
                  run_cont <= 1'b0;
               end else if (mod_tick && conv_cnt == period_last) begin
                  conv_cnt <= 16'h0000;
                  if (duty_left == 2'h0) begin
                     state <= S_CONV;
                  end else begin
                     duty_left <= duty_left - 2'h1;
                  end
               end else if (mod_tick) begin
                  conv_cnt <= conv_cnt + 16'h0001;
               end
            end
            S_IDLE: begin
               if (sleep_command) begin
                  state <= S_SLEEP;
               end
            end
            S_SLEEP: begin
               state <= S_SLEEP;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // output buffer
   always @(posedge CLOCK) begin
      if (RST || cmd_reset) begin
         result <= `RESULT_RST;
      end else if (conv_done) begin
         if (temp_sensor_select) begin
            result <= {TEMP_IN, `TEMP_PAD};
         end else begin
            result <= SAMPLE_IN;
         end
      end
   end

   // data ready; new data wins over a read in the same cycle
   always @(posedge CLOCK) begin
      if (RST || cmd_reset) begin
         DATA_READY_N <= 1'b1;
      end else if (conv_done) begin
         DATA_READY_N <= 1'b0;
      end else if (data_read) begin
         DATA_READY_N <= 1'b1;
      end else if (state == S_CONV && run_cont && !duty && mod_tick && conv_cnt == ready_rise) begin
         // unread data: brief high pulse ahead of the next falling edge
         DATA_READY_N <= 1'b1;
      end
   end

   // front-end control, registered
   always @(posedge CLOCK) begin
      if (RST) begin
         ANALOG_ON <= 1'b0;
         OSC_ON <= 1'b1;
         EXCITATION_ON <= 1'b0;
         INTERNAL_REF <= 1'b1;
         TEMP_SENSE <= 1'b0;
         INPUT_CFG <= `CFG0_RST;
         CONVERTING <= 1'b0;
      end else begin
         ANALOG_ON <= busy_conv;
         OSC_ON <= busy_conv | (state == S_DUTY) | in_reset;
         // excitation stays on between single-shot conversions, off in sleep
         EXCITATION_ON <= (cfg3[`EXC_MSB:`EXC_LSB] != 3'h0) & ~in_reset & (state != S_SLEEP);
         INTERNAL_REF <= temp_sensor_select | (cfg2[`VREF_MSB:`VREF_LSB] == 2'h0);
         TEMP_SENSE <= temp_sensor_select;
         INPUT_CFG <= temp_sensor_select ? `CFG0_RST : cfg0;
         CONVERTING <= (state == S_CONV);
      end
   end

endmodule // adc_conversion_mode_sequencer

// ---- hw/adc_seq_regs.vh ----
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// wishbone byte offsets
`define OFS_CFG0 8'h00
`define OFS_CFG1 8'h04
`define OFS_CFG2 8'h08
`define OFS_CFG3 8'h0C
`define OFS_CMD 8'h10
`define OFS_DATA 8'h14
`define OFS_STATUS 8'h18

// reset values
`define CFG0_RST 8'h00
`define CFG1_RST 8'h00
`define CFG2_RST 8'h00
`define CFG3_RST 8'h00
`define RESULT_RST 24'h00_0000

// cfg1 fields
`define DR_MSB 7
`define DR_LSB 5
`define OPM_MSB 4
`define OPM_LSB 3
`define CM_BIT 2
`define TS_BIT 1
// cfg2 fields
`define VREF_MSB 7
`define VREF_LSB 6
// cfg3 fields
`define EXC_MSB 7
`define EXC_LSB 5

// operating mode encoding
`define OPM_NORMAL 2'h0
`define OPM_DUTY 2'h1
`define OPM_TURBO 2'h2

// command byte, upper seven bits, last bit ignored
`define CMD_START 7'h04
`define CMD_SLEEP 7'h01
`define CMD_RESET 7'h03

// temperature placement
`define TEMP_W 14
`define TEMP_PAD 10'h000

// timing
`define CLK_PERIOD_NS 8
`define PWRUP_TIME_NS 50000
`define PWRUP_CYCLES ((`PWRUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_DLY_NORMAL 8'hD2
`define START_DLY_TURBO 8'h72
`define MOD_DIV_NORMAL 4'hF
`define MOD_DIV_TURBO 4'h7
`define DUTY_IDLE_PERIODS 2'h3

// modulator ticks per conversion, by rate code
`define PER_DR0 16'h3200
`define PER_DR1 16'h1639
`define PER_DR2 16'h0B1C
`define PER_DR3 16'h05B7
`define PER_DR4 16'h0308
`define PER_DR5 16'h01AB
`define PER_DR6 16'h0100

`endif

// ---- hw/mod_tick_gen.v ----
`include "adc_seq_regs.vh"

module mod_tick_gen (
   // clock and reset
   input wire clk,
   input wire rst,
   // control
   input wire run,
   input wire turbo,
   // modulator clock strobe
   output reg tick
);

   reg [3:0] cnt;
   wire [3:0] last = turbo ? `MOD_DIV_TURBO : `MOD_DIV_NORMAL;

   // held in reset while stopped so each conversion starts phase aligned
   always @(posedge clk) begin
      if (rst || !run) begin
         cnt <= 4'h0;
         tick <= 1'b0;
      end else if (cnt >= last) begin
         cnt <= 4'h0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
         tick <= 1'b0;
      end
   end

endmodule // mod_tick_gen

// ---- tb/adc_conversion_mode_sequencer_test.sv ----
module adc_conversion_mode_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, cyc, stb, we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rd;
   logic [13:0] temp_code;
   logic [23:0] sample;
   wire [31:0] rdat;
   wire ack, analog_on, osc_on, exc_on, int_ref, temp_sense, converting, ready_n;
   wire [7:0] input_cfg;
   wire [23:0] sample_in;
   wire [13:0] temp_in;
   int n_mismatch, comparisons, n, i;
   logic [13:0] codes [5] = '{14'h1000, 14'h0320, 14'h0000, 14'h3B00, 14'h3CE0};
   logic [7:0] modes [3] = '{8'hC0, 8'hD0, 8'hA0};
   int dly [3] = '{210, 114, 210};
   int len [3] = '{128, 64, 208};

   always #4 clock = ~clock;

   frontend_model u_front (.CLOCK(clock), .temp_code(temp_code), .sample(sample),
      .SAMPLE_IN(sample_in), .TEMP_IN(temp_in));
   adc_conversion_mode_sequencer #(.RESET_CYCLES(20), .PERIOD_SHIFT(5)) DUT (
      .CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SAMPLE_IN(sample_in),
      .TEMP_IN(temp_in), .ANALOG_ON(analog_on), .OSC_ON(osc_on), .EXCITATION_ON(exc_on),
      .INTERNAL_REF(int_ref), .TEMP_SENSE(temp_sense), .INPUT_CFG(input_cfg),
      .CONVERTING(converting), .DATA_READY_N(ready_n));

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clock);
      if (ack !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h00_0000, d}, 4'h1);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000, 4'h1);
      chk(what, exp, rd);
   endtask

   task automatic wait_ready(input int lim);
      int k;
      for (k = 0; k < lim && ready_n !== 1'b0; k++) @(posedge clock);
      if (ready_n !== 1'b0) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   initial begin
      clock = 1'b0;
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0000_0000;
      temp_code = 14'h0000;
      sample = 24'h12_3456;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      // host stays quiet until the power-up conversion signals ready
      wait_ready(8000);
      rd_chk("status state", 8'h18, 32'h0000_0001);
      chk("osc off idle", 32'h0, {31'h0, osc_on});
      rd_chk("default data", 8'h14, {8'h00, sample});
      chk("ready after read", 32'h1, {31'h0, ready_n});
      bus(1'b1, 8'h0C, 32'h0000_00E0, 4'h0);
      for (i = 0; i < 4; i++) rd_chk("cfg default", 8'(4 * i), 32'h0000_0000);
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
      $display("test power-up done");

      wr(8'h00, 8'hA5);
      wr(8'h08, 8'h40);
      for (i = 0; i < 5; i++) begin
         temp_code <= codes[i];
         // lands in the start delay on the first pass, which must restart
         wr(8'h04, 8'hC2);
         wait_ready(2000);
         chk("temp select", 32'h1, {31'h0, temp_sense});
         chk("temp ref", 32'h1, {31'h0, int_ref});
         chk("temp inputs", 32'h0, {24'h0, input_cfg});
         rd_chk("temp word", 8'h14, {8'h00, codes[i], 10'h000});
         chk("temp msb", {24'h0, codes[i][13:6]}, {24'h0, rd[23:16]});
      end
      wr(8'h04, 8'hC0);
      wait_ready(2000);
      chk("ext ref", 32'h0, {31'h0, int_ref});
      chk("inputs back", 32'hA5, {24'h0, input_cfg});
      rd_chk("input data", 8'h14, {8'h00, sample});
      $display("test sensor done");

      for (i = 0; i < 3; i++) begin
         wr(8'h04, modes[i]);
         wait_ready(2000);
         rd_chk("mode data", 8'h14, {8'h00, sample});
         wr(8'h10, 8'(8 + (i % 2)));
         for (n = 0; n < 400 && converting !== 1'b1; n++) @(posedge clock);
         chk("start delay", 32'h1, {31'h0, n >= dly[i] - 2 && n <= dly[i] + 2});
         for (n = 0; n < 400 && ready_n !== 1'b0; n++) @(posedge clock);
         chk("conv length", 32'h1, {31'h0, n >= len[i] - 3 && n <= len[i] + 3});
         rd_chk("mode data", 8'h14, {8'h00, sample});
      end
      $display("test modes done");

      wr(8'h0C, 8'h20);
      wr(8'h04, 8'hC4);
      wait_ready(2000);
      rd_chk("single data", 8'h14, {8'h00, sample});
      chk("exc idle", 32'h1, {31'h0, exc_on});
      wr(8'h10, 8'h08);
      for (i = 0; i < 2; i++) begin
         wait_ready(2000);
         rd_chk("cont data", 8'h14, {8'h00, sample});
      end
      rd_chk("cont running", 8'h18, 32'h0000_002B);
      repeat (60) @(posedge clock);
      wr(8'h00, 8'h00);
      for (n = 0; n < 400 && ready_n !== 1'b0; n++) @(posedge clock);
      chk("restart length", 32'h1, {31'h0, n >= 118 && n <= 134});
      rd_chk("cont data", 8'h14, {8'h00, sample});
      wr(8'h10, 8'h02);
      wait_ready(2000);
      rd_chk("asleep", 8'h14, {8'h00, sample});
      rd_chk("sleep state", 8'h18, 32'h0000_000D);
      chk("sleep osc", 32'h0, {31'h0, osc_on});
      chk("sleep exc", 32'h0, {31'h0, exc_on});
      wr(8'h10, 8'h08);
      wait_ready(2000);
      rd_chk("wake data", 8'h14, {8'h00, sample});
      wait_ready(2000);
      rd_chk("awake state", 8'h18, 32'h0000_0023);
      $display("test continuous done");

      // duty: one conversion then three idle periods, 32 ticks between results
      wr(8'h04, 8'hCC);
      wr(8'h10, 8'h08);
      rd_chk("duty data", 8'h14, {8'h00, sample});
      wait_ready(2000);
      rd_chk("duty data", 8'h14, {8'h00, sample});
      chk("duty analog off", 32'h0, {31'h0, analog_on});
      chk("duty osc on", 32'h1, {31'h0, osc_on});
      // three cycles of the read already spent
      for (n = 0; n < 1000 && ready_n !== 1'b0; n++) @(posedge clock);
      chk("duty period", 32'd509, 32'(n));
      $display("test duty done");

      wr(8'h10, 8'h06);
      chk("reset ready", 32'h1, {31'h0, ready_n});
      wait_ready(8000);
      rd_chk("reset state", 8'h18, 32'h0000_0001);
      rd_chk("reset cfg1", 8'h04, 32'h0000_0000);
      chk("reset exc", 32'h0, {31'h0, exc_on});
      $display("test reset command done");
      report_and_stop();
   end
endmodule // adc_conversion_mode_sequencer_test

// ---- tb/adc_seq_monitor.sv ----
module adc_seq_monitor (
   // clock and reset
   input wire CLOCK,
   input wire RST,
   // bus
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   // front-end control
   input wire ANALOG_ON,
   input wire OSC_ON,
   input wire INTERNAL_REF,
   input wire TEMP_SENSE,
   input wire [7:0] INPUT_CFG,
   input wire CONVERTING,
   input wire DATA_READY_N
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_ack_pulse;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   a_ack_one_wait: assert property (s_req |=> s_ack_pulse)
      else $error("bus answer not a single pulse one cycle after request");
   a_ack_needs_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("bus answer without request");
   a_dat_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
      else $error("read data outside answer cycle");
   a_temp_ref: assert property (TEMP_SENSE && $past(TEMP_SENSE) |-> INTERNAL_REF)
      else $error("sensor mode without internal reference");
   a_temp_inputs: assert property (TEMP_SENSE && $past(TEMP_SENSE) |-> INPUT_CFG == 8'h00)
      else $error("input settings leak in sensor mode");
   a_conv_powered: assert property (CONVERTING |-> ANALOG_ON && OSC_ON)
      else $error("conversion with front end off");
   a_lowpow_quiet: assert property (!OSC_ON |-> !ANALOG_ON && !CONVERTING)
      else $error("analog active with oscillator off");
   a_ready_source: assert property ($fell(DATA_READY_N) |-> $past(CONVERTING))
      else $error("ready without a conversion");
   a_reset_defaults: assert property (disable iff (1'b0)
      RST |=> DATA_READY_N && !CONVERTING && !ANALOG_ON && INTERNAL_REF && !TEMP_SENSE)
      else $error("reset state wrong");
endmodule // adc_seq_monitor

bind adc_conversion_mode_sequencer adc_seq_monitor u_monitor (
   .CLOCK(CLOCK),
   .RST(RST),
   .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I),
   .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O),
   .ANALOG_ON(ANALOG_ON),
   .OSC_ON(OSC_ON),
   .INTERNAL_REF(INTERNAL_REF),
   .TEMP_SENSE(TEMP_SENSE),
   .INPUT_CFG(INPUT_CFG),
   .CONVERTING(CONVERTING),
   .DATA_READY_N(DATA_READY_N)
);

// ---- tb/frontend_model.sv ----
module frontend_model (
   // clock
   input wire CLOCK,
   // codes set by the bench
   input wire [13:0] temp_code,
   input wire [23:0] sample,
   // results to the sequencer
   output logic [23:0] SAMPLE_IN,
   output logic [13:0] TEMP_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   // sensor count is twos complement, 0.03125 C each
   always @(posedge CLOCK) begin
      TEMP_IN <= temp_code;
      SAMPLE_IN <= sample;
   end
endmodule // frontend_model
